// ### design/sram_host_pkg.sv
package sram_host_pkg;
  // memory geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int DEPTH = 32768;
  // timing figures in ns and clock period
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_READ_CYCLE_NS = 35;
  localparam int T_WRITE_PULSE_NS = 30;
  localparam int T_DATA_SETUP_NS = 15;
  localparam int T_WRITE_RECOVERY_NS = 2;
  // least times round up to whole cycles, never below one
  localparam int RC_CYC_RAW = (T_READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC = (RC_CYC_RAW < 1) ? 1 : RC_CYC_RAW;
  localparam int WP_CYC_RAW = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (WP_CYC_RAW < 1) ? 1 : WP_CYC_RAW;
  localparam int DS_CYC_RAW = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DS_CYC = (DS_CYC_RAW < 1) ? 1 : DS_CYC_RAW;
  localparam int WR_CYC_RAW = (T_WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_CYC = (WR_CYC_RAW < 1) ? 1 : WR_CYC_RAW;
  // extra wait so the two-flop data synchroniser holds the read byte
  localparam int DQ_SYNC_CYC = 1;
  localparam int CNT_W = 4;
  // user request carrier
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_s;
  // memory pin carrier, strobes active low
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
  } pins_s;
endpackage

// ### design/sram_host.sv
// Operation
// RULE1 - a store happens only while select and write strobe are both low
// RULE2 - a write starts at the later falling edge of select or strobe
// RULE3 - a write ends at the earlier rising edge; data latched there
// RULE4 - the select and strobe overlap lasts at least the write pulse width
// RULE5 - memory floats its data pins if select high, enable high, strobe low
// RULE6 - the host keeps the write strobe high through every read
// RULE7 - output enable may sit at either level during a write
// RULE8 - memory echoes the byte being written when its outputs are on
// RULE9 - after retention, select stays high one read cycle before access
// RULE10 - select low, enable low, strobe high: memory drives the stored byte
// RULE11 - select low and strobe low: memory stores the data pin byte
// RULE12 - select high: standby, controls ignored, data pins float
// RULE13 - memory holds 32768 bytes chosen by a 15-bit address
// RULE14 - the host holds the address steady while select and strobe are low
`timescale 1ns/1ps
module sram_host (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic REQ_VALID_IN,
  output logic REQ_READY_OUT,
  input wire sram_host_pkg::req_s REQ_IN,
  input wire logic RETENTION_EXIT_IN,
  output logic RDATA_VALID_OUT,
  output logic [sram_host_pkg::DATA_W-1:0] RDATA_OUT,
  output logic WDONE_OUT,
  output sram_host_pkg::pins_s PINS_OUT,
  output logic [sram_host_pkg::DATA_W-1:0] DQ_OUT,
  output logic DQ_OE_OUT,
  input wire logic [sram_host_pkg::DATA_W-1:0] DQ_IN
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_GUARD, ST_RD_SEL, ST_RD_WAIT, ST_RD_DONE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_REC
  } state_e;

  state_e state_reg, state_next;
  logic [sram_host_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [sram_host_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [sram_host_pkg::DATA_W-1:0] wdata_reg, wdata_next;
  logic [sram_host_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic cs_n_reg, cs_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic dq_oe_reg, dq_oe_next;
  logic rvalid_reg, rvalid_next;
  logic wdone_reg, wdone_next;
  logic [sram_host_pkg::DATA_W-1:0] dq_sync1_reg, dq_sync2_reg;
  logic ret_sync1_reg, ret_sync2_reg;

  typedef logic [sram_host_pkg::CNT_W-1:0] cnt_t;
  // last cycle of a counted wait
  function automatic logic cnt_last(input cnt_t c);
    return c <= cnt_t'(1);
  endfunction

  // one step down of a counted wait
  function automatic cnt_t cnt_dec(input cnt_t c);
    return c - cnt_t'(1);
  endfunction

  // two-stage synchronisers for pin inputs
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      dq_sync1_reg <= 8'h00;
      dq_sync2_reg <= 8'h00;
      ret_sync1_reg <= 1'b0;
      ret_sync2_reg <= 1'b0;
    end else begin
      dq_sync1_reg <= DQ_IN;
      dq_sync2_reg <= dq_sync1_reg;
      ret_sync1_reg <= RETENTION_EXIT_IN;
      ret_sync2_reg <= ret_sync1_reg;
    end
  end

  // access sequencer next-state
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    cs_n_next = cs_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    dq_oe_next = dq_oe_reg;
    rvalid_next = 1'b0;
    wdone_next = 1'b0;
    unique case (state_reg)
      // park the pins; take a retention exit or a request
      ST_IDLE: begin
        cs_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        dq_oe_next = 1'b0;
        if (ret_sync2_reg) begin
          state_next = ST_GUARD; // RULE9
          cnt_next = sram_host_pkg::CNT_W'(sram_host_pkg::RC_CYC);
        end else if (REQ_VALID_IN) begin
          addr_next = REQ_IN.addr;
          wdata_next = REQ_IN.wdata;
          cs_n_next = 1'b0;
          if (REQ_IN.write) begin
            // drive data first, strobe later: strobe fall starts the write
            dq_oe_next = 1'b1; // RULE2
            oe_n_next = 1'b1; // RULE7
            state_next = ST_WR_SETUP;
            cnt_next = sram_host_pkg::CNT_W'(sram_host_pkg::DS_CYC);
          end else begin
            oe_n_next = 1'b0; // RULE10
            state_next = ST_RD_SEL;
            cnt_next = sram_host_pkg::CNT_W'(sram_host_pkg::RC_CYC);
          end
        end
      end
      ST_GUARD: begin
        // select held high one read cycle after retention
        if (cnt_last(cnt_reg)) begin
          state_next = ST_IDLE; // RULE9
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      // byte on the pins; wait the read cycle plus synchroniser lag
      ST_RD_SEL: begin
        we_n_next = 1'b1; // RULE6
        state_next = ST_RD_WAIT;
        cnt_next = sram_host_pkg::CNT_W'(sram_host_pkg::RC_CYC + sram_host_pkg::DQ_SYNC_CYC);
      end
      // capture once the synchronised byte is settled
      ST_RD_WAIT: begin
        if (cnt_last(cnt_reg)) begin
          rdata_next = dq_sync2_reg;
          state_next = ST_RD_DONE;
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      // deselect and report the byte
      ST_RD_DONE: begin
        cs_n_next = 1'b1; // RULE12
        oe_n_next = 1'b1;
        rvalid_next = 1'b1;
        state_next = ST_IDLE;
      end
      // data settles on the bus before the strobe falls
      ST_WR_SETUP: begin
        if (cnt_last(cnt_reg)) begin
          we_n_next = 1'b0; // RULE1 RULE11
          state_next = ST_WR_PULSE;
          cnt_next = sram_host_pkg::CNT_W'(sram_host_pkg::WP_CYC);
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      ST_WR_PULSE: begin
        // address and data stay fixed while both strobes are low
        if (cnt_last(cnt_reg)) begin
          we_n_next = 1'b1; // RULE3 RULE4 RULE14
          state_next = ST_WR_REC;
          cnt_next = sram_host_pkg::CNT_W'(sram_host_pkg::WR_CYC);
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
      // strobe up, data held for recovery, then release
      ST_WR_REC: begin
        if (cnt_last(cnt_reg)) begin
          cs_n_next = 1'b1;
          dq_oe_next = 1'b0;
          wdone_next = 1'b1;
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_dec(cnt_reg);
        end
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      addr_reg <= 15'h0000;
      wdata_reg <= 8'h00;
      rdata_reg <= 8'h00;
      cs_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      wdone_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      cs_n_reg <= cs_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      dq_oe_reg <= dq_oe_next;
      rvalid_reg <= rvalid_next;
      wdone_reg <= wdone_next;
    end
  end

  // request handshake and answers
  assign REQ_READY_OUT = (state_reg == ST_IDLE) && !ret_sync2_reg; // RULE9
  assign RDATA_VALID_OUT = rvalid_reg;
  assign RDATA_OUT = rdata_reg;
  assign WDONE_OUT = wdone_reg;

  // memory pins; enable stays high during writes, which the memory ignores
  assign PINS_OUT.cs_n = cs_n_reg;
  assign PINS_OUT.oe_n = oe_n_reg;
  assign PINS_OUT.we_n = we_n_reg;
  assign PINS_OUT.addr = addr_reg;

  // write data and its bus enable
  assign DQ_OUT = wdata_reg;
  assign DQ_OE_OUT = dq_oe_reg;
endmodule

// ### tb/sram_host_props.sv
`timescale 1ns/1ps
module sram_host_props (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic REQ_VALID_IN,
  input wire logic REQ_READY_OUT,
  input wire sram_host_pkg::req_s REQ_IN,
  input wire logic RETENTION_EXIT_IN,
  input wire logic RDATA_VALID_OUT,
  input wire logic WDONE_OUT,
  input wire sram_host_pkg::pins_s PINS_OUT,
  input wire logic DQ_OE_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESET_N_IN);
  // one request taken, of the given kind
  sequence take_s(logic w);
    REQ_VALID_IN && REQ_READY_OUT && REQ_IN.write == w;
  endsequence
  // strobe low one cycle inside select, then raised first
  sequence wr_pulse_s;
    !PINS_OUT.cs_n ##1 PINS_OUT.we_n && !PINS_OUT.cs_n;
  endsequence
  rd_strobe_a: assert property (!PINS_OUT.oe_n |-> PINS_OUT.we_n)
    else $error("strobe low in read");
  wr_enable_a: assert property (!PINS_OUT.we_n |-> PINS_OUT.oe_n)
    else $error("enable low in write");
  addr_hold_a: assert property (!PINS_OUT.cs_n && !PINS_OUT.we_n |-> $stable(PINS_OUT.addr))
    else $error("address moved in write");
  wr_frame_a: assert property ($fell(PINS_OUT.we_n) |-> wr_pulse_s)
    else $error("write frame wrong");
  wr_data_a: assert property (!PINS_OUT.we_n |-> DQ_OE_OUT)
    else $error("data not driven");
  bus_free_a: assert property (!PINS_OUT.oe_n || PINS_OUT.cs_n |-> !DQ_OE_OUT)
    else $error("host drives bus");
  rd_lat_a: assert property (take_s(1'b0) |-> ##5 RDATA_VALID_OUT)
    else $error("read answer late");
  wr_lat_a: assert property (take_s(1'b1) |-> ##4 WDONE_OUT)
    else $error("write answer late");
  ret_hold_a: assert property (RETENTION_EXIT_IN [*4] |-> !REQ_READY_OUT)
    else $error("request open after exit");
endmodule
bind sram_host sram_host_props i_props (.CLK_SYS_IN(CLK_SYS_IN), .RESET_N_IN(RESET_N_IN),
  .REQ_VALID_IN(REQ_VALID_IN), .REQ_READY_OUT(REQ_READY_OUT), .REQ_IN(REQ_IN),
  .RETENTION_EXIT_IN(RETENTION_EXIT_IN), .RDATA_VALID_OUT(RDATA_VALID_OUT),
  .WDONE_OUT(WDONE_OUT), .PINS_OUT(PINS_OUT), .DQ_OE_OUT(DQ_OE_OUT));

// ### tb/sram_model.sv
`timescale 1ns/1ps
module sram_model (
  input wire logic clk_in,
  input wire sram_host_pkg::pins_s pins_in,
  input wire logic [7:0] dq_host_in,
  input wire logic dq_oe_in,
  output logic [7:0] dq_out
);
  logic [7:0] mem [0:sram_host_pkg::DEPTH-1];
  logic [7:0] float_q = 8'hA5;
  logic wr_on;
  logic drv;
  // store window and read drive
  assign wr_on = !pins_in.cs_n && !pins_in.we_n;
  assign drv = !pins_in.cs_n && !pins_in.oe_n && pins_in.we_n;
  // byte latched as the overlap ends
  always @(negedge wr_on) mem[pins_in.addr] = dq_host_in;
  // released bus toggles, never keeps its last value
  always @(posedge clk_in) float_q <= ~float_q;
  // wire level; in a write the host byte is what the pins show
  assign dq_out = dq_oe_in ? dq_host_in : drv ? mem[pins_in.addr] : float_q;
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, valid = 0, ret = 0;
  logic ready, rvalid, wdone, dq_oe;
  logic [7:0] rdata, dq_out, dq_in;
  sram_host_pkg::req_s req = '0;
  sram_host_pkg::pins_s pins;
  int num_errors = 0, checked = 0, cycles = 0;
  logic [7:0] ref_mem [int];
  initial forever #50 clk = ~clk;
  sram_host i_sram_host (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(valid),
    .REQ_READY_OUT(ready), .REQ_IN(req), .RETENTION_EXIT_IN(ret), .RDATA_VALID_OUT(rvalid),
    .RDATA_OUT(rdata), .WDONE_OUT(wdone), .PINS_OUT(pins), .DQ_OUT(dq_out),
    .DQ_OE_OUT(dq_oe), .DQ_IN(dq_in));
  sram_model i_sram_model (.clk_in(clk), .pins_in(pins), .dq_host_in(dq_out),
    .dq_oe_in(dq_oe), .dq_out(dq_in));
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request through the handshake, then its answer and latency
  task automatic access(logic wr, logic [14:0] a, logic [7:0] d);
    int n, lat;
    @(negedge clk) req = '{wr, a, d};
    valid = 1;
    while (!ready) @(negedge clk);
    @(negedge clk) valid = 0;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (!(wr ? wdone : rvalid) && n < 20);
    // write: setup, pulse, recovery; read: select, cycle, sync lag, done
    lat = wr ? sram_host_pkg::DS_CYC + sram_host_pkg::WP_CYC + sram_host_pkg::WR_CYC
             : sram_host_pkg::RC_CYC + sram_host_pkg::DQ_SYNC_CYC + 2;
    check(8'(n), 8'(lat));
    if (wr) ref_mem[a] = d;
    else check(rdata, ref_mem[a]);
  endtask
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      num_errors++;
      complete_run;
    end
  end
  initial begin
    logic [14:0] a;
    void'($urandom(20864));
    repeat (20) @(negedge clk);
    rst_n = 1;
    // end locations, overwrite, back to back
    access(1, 15'h0000, 8'h5A);
    access(1, 15'h7FFF, 8'hA5);
    access(0, 15'h0000, 8'h00);
    access(1, 15'h7FFF, 8'h3C);
    access(0, 15'h7FFF, 8'h00);
    // random mix over a small pool at the bottom and the middle, 0000-000F and 4000-400F
    repeat (60) begin
      a = {1'($urandom), 10'h000, 4'($urandom)};
      if (ref_mem.exists(a) && $urandom % 2) access(0, a, 8'h00);
      else access(1, a, 8'($urandom));
    end
    // exit from retention closes the request port
    @(negedge clk) ret = 1;
    repeat (5) @(negedge clk);
    check({7'h00, ready}, 8'h00);
    ret = 0;
    access(0, 15'h0000, 8'h00);
    complete_run;
  end
endmodule
